// *** design/spi_cfg_pkg.sv ***
`default_nettype none
package spi_cfg_pkg;
    // Byte offsets on the register bus
    localparam logic [3:0] MODE_OFS = 4'h0;
    localparam logic [3:0] XFER_OFS = 4'h4;
    // spi_mode_config fields
    localparam int DIV_LSB = 16;
    localparam int DIV_MSB = 23;
    localparam int CS_LSB = 12;
    localparam int CS_MSB = 13;
    localparam int RXPH_BIT = 10;
    localparam int TXPH_BIT = 9;
    localparam int POL_BIT = 8;
    localparam int SRST_BIT = 1;
    localparam int ACT_BIT = 0;
    localparam logic [31:0] MODE_RST = 32'h0000_0000;
    localparam logic [31:0] MODE_WMASK = 32'h00FF_3701;
    // Transfer register fields
    localparam int DATA_MSB = 7;
    localparam int BUSY_BIT = 16;
    // Chip-select codes
    localparam logic [1:0] CS_SEL0 = 2'h0;
    localparam logic [1:0] CS_SEL1 = 2'h1;
    // Divider: zero means 256, edges come every half period
    localparam logic [8:0] DIV_ZERO_VAL = 9'h100;
    localparam logic [4:0] LAST_EDGE = 5'h0F;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOAD = 2'b01,
        ST_SHIFT = 2'b10,
        ST_DONE = 2'b11
    } phase_t;
endpackage
`default_nettype wire

// *** design/spi_edge_timer.sv ***
`default_nettype none
module spi_edge_timer
(
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic RUN,
    input wire logic [7:0] DIV,
    output logic TICK
);
    import spi_cfg_pkg::*;

    typedef struct packed {
        logic [7:0] cnt;
        logic [7:0] gap;
    } timer_t;

    timer_t state_ff;
    timer_t nxt_state;
    logic [8:0] full_div;
    logic [7:0] half_m1;
    logic [7:0] exp_gap;

    // Each clock edge is half a divided period; odd values round down
    always_comb
    begin
        full_div = (DIV == 8'h00) ? DIV_ZERO_VAL : {1'b0, DIV};
        half_m1 = (full_div[8:1] == 8'h00) ? 8'h00 : full_div[8:1] - 8'h01;
        // Separate reckoning of the half period, so the check below is not circular
        if (DIV == 8'h00)
            exp_gap = DIV_ZERO_VAL[8:1] - 8'h01;
        else if (DIV[7:1] == 7'h00)
            exp_gap = 8'h00;
        else
            exp_gap = {1'b0, DIV[7:1]} - 8'h01;
    end

    assign TICK = RUN && (state_ff.cnt == half_m1);

    always_comb
    begin
        nxt_state = state_ff;
        if (!RUN || TICK)
        begin
            nxt_state.cnt = 8'h00;
            nxt_state.gap = 8'h00;
        end
        else
        begin
            nxt_state.cnt = state_ff.cnt + 8'h01;
            nxt_state.gap = state_ff.gap + 8'h01;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
            state_ff <= '0;
        else
            state_ff <= nxt_state;
    end

    AST_DIV_SPACING: assert property (@(posedge CLK) disable iff (!RESET_N)
        TICK |-> state_ff.gap == exp_gap)
        else $error("edge tick spacing does not follow divider");
endmodule
`default_nettype wire

// *** design/spi_clock_phase_cs_config.sv ***
// Register access over Avalon-MM was chosen for this implementation.
`default_nettype none
module spi_clock_phase_cs_config
(
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    output logic SPI_CLK,
    output logic SPI_CS0_N,
    output logic SPI_CS1_N,
    output logic SPI_MOSI,
    input wire logic SPI_MISO
);
    import spi_cfg_pkg::*;

    typedef struct packed {
        logic [31:0] mode;
        phase_t phase;
        logic ack;
        logic [31:0] rdata;
        logic [7:0] tx_sr;
        logic [7:0] rx_sr;
        logic [7:0] rx_data;
        logic [4:0] edge_cnt;
        logic sck;
        logic [1:0] cs_n;
        logic mosi;
        logic miso_meta;
        logic miso_sync;
    } core_t;

    core_t state_ff;
    core_t nxt_state;
    logic tick;
    logic req;
    logic wr;
    logic lead;
    logic sample;
    logic launch;
    logic pol;
    logic rx_ph;
    logic tx_ph;
    logic [1:0] cs_sel;

    assign pol = state_ff.mode[POL_BIT];
    assign rx_ph = state_ff.mode[RXPH_BIT];
    assign tx_ph = state_ff.mode[TXPH_BIT];
    assign cs_sel = state_ff.mode[CS_MSB:CS_LSB];

    spi_edge_timer u_timer
    (
        .CLK(CLK),
        .RESET_N(RESET_N),
        .RUN(state_ff.phase == ST_SHIFT),
        .DIV(state_ff.mode[DIV_MSB:DIV_LSB]),
        .TICK(tick)
    );

    // One wait cycle on every access, answer on the second
    assign req = AVS_READ || AVS_WRITE;
    assign AVS_WAITREQUEST = req && !state_ff.ack;
    assign wr = AVS_WRITE && state_ff.ack;

    // Even edges lead away from idle level, odd edges trail back
    assign lead = !state_ff.edge_cnt[0];
    assign sample = tick && (lead ^ rx_ph);
    // Trailing launch skips the last edge: first bit went out at load
    assign launch = tick && (lead == tx_ph) && (state_ff.edge_cnt != LAST_EDGE);

    always_comb
    begin
        nxt_state = state_ff;
        nxt_state.miso_meta = SPI_MISO;
        nxt_state.miso_sync = state_ff.miso_meta;
        nxt_state.ack = req && !state_ff.ack;

        if (AVS_READ && !state_ff.ack)
        begin
            case (AVS_ADDRESS)
                MODE_OFS: nxt_state.rdata = state_ff.mode & MODE_WMASK;
                XFER_OFS:
                begin
                    nxt_state.rdata = 32'h0000_0000;
                    nxt_state.rdata[DATA_MSB:0] = state_ff.rx_data;
                    nxt_state.rdata[BUSY_BIT] = (state_ff.phase != ST_IDLE);
                end
                default: nxt_state.rdata = 32'h0000_0000;
            endcase
        end

        if (wr && AVS_ADDRESS == MODE_OFS)
        begin
            for (int b = 0; b < 4; b++)
            begin
                if (AVS_BYTEENABLE[b])
                begin
                    nxt_state.mode[b*8 +: 8] = AVS_WRITEDATA[b*8 +: 8] & MODE_WMASK[b*8 +: 8];
                end
            end
        end

        // Start only from idle and only while the block is active
        if (wr && AVS_ADDRESS == XFER_OFS && AVS_BYTEENABLE[0]
            && state_ff.phase == ST_IDLE && state_ff.mode[ACT_BIT])
        begin
            nxt_state.tx_sr = AVS_WRITEDATA[DATA_MSB:0];
            nxt_state.phase = ST_LOAD;
        end

        case (state_ff.phase)
            ST_IDLE:
            begin
                nxt_state.cs_n = 2'b11;
                nxt_state.sck = nxt_state.mode[POL_BIT];
            end
            ST_LOAD:
            begin
                nxt_state.cs_n = 2'b11;
                if (cs_sel == CS_SEL0)
                    nxt_state.cs_n[0] = 1'b0;
                else if (cs_sel == CS_SEL1)
                    nxt_state.cs_n[1] = 1'b0;
                if (!tx_ph)
                begin
                    nxt_state.mosi = state_ff.tx_sr[7];
                    nxt_state.tx_sr = {state_ff.tx_sr[6:0], 1'b0};
                end
                nxt_state.rx_sr = 8'h00;
                nxt_state.edge_cnt = 5'h00;
                nxt_state.phase = ST_SHIFT;
            end
            ST_SHIFT:
            begin
                if (tick)
                begin
                    nxt_state.sck = !state_ff.sck;
                    nxt_state.edge_cnt = state_ff.edge_cnt + 5'h01;
                    if (state_ff.edge_cnt == LAST_EDGE)
                        nxt_state.phase = ST_DONE;
                end
                if (sample)
                    nxt_state.rx_sr = {state_ff.rx_sr[6:0], state_ff.miso_sync};
                if (launch)
                begin
                    nxt_state.mosi = state_ff.tx_sr[7];
                    nxt_state.tx_sr = {state_ff.tx_sr[6:0], 1'b0};
                end
            end
            ST_DONE:
            begin
                nxt_state.cs_n = 2'b11;
                nxt_state.rx_data = state_ff.rx_sr;
                nxt_state.phase = ST_IDLE;
            end
            default: nxt_state.phase = ST_IDLE;
        endcase

        // Clearing activate mid-byte aborts it; select and clock go inactive at once, MOSI keeps its level
        if (!state_ff.mode[ACT_BIT] && state_ff.phase != ST_IDLE)
        begin
            nxt_state.phase = ST_IDLE;
            nxt_state.cs_n = 2'b11;
            nxt_state.sck = nxt_state.mode[POL_BIT];
        end

        // Self-clearing soft reset; the bus answer itself is kept
        if (wr && AVS_ADDRESS == MODE_OFS && AVS_BYTEENABLE[0] && AVS_WRITEDATA[SRST_BIT])
        begin
            nxt_state.mode = MODE_RST;
            nxt_state.phase = ST_IDLE;
            nxt_state.cs_n = 2'b11;
            nxt_state.sck = MODE_RST[POL_BIT];
            nxt_state.mosi = 1'b0;
            nxt_state.rx_data = 8'h00;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            state_ff <= '0;
            state_ff.mode <= MODE_RST;
            state_ff.phase <= ST_IDLE;
            state_ff.cs_n <= 2'b11;
        end
        else
            state_ff <= nxt_state;
    end

    assign AVS_READDATA = state_ff.rdata;
    assign SPI_CLK = state_ff.sck;
    assign SPI_CS0_N = state_ff.cs_n[0];
    assign SPI_CS1_N = state_ff.cs_n[1];
    assign SPI_MOSI = state_ff.mosi;

    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);

    sequence byte_running;
        state_ff.phase == ST_SHIFT;
    endsequence

    sequence byte_closing;
        state_ff.phase == ST_DONE ##1 state_ff.phase == ST_IDLE;
    endsequence

    AST_CS_CODE0: assert property (!SPI_CS0_N |-> cs_sel == CS_SEL0 && SPI_CS1_N)
        else $error("select zero low without code 00");
    AST_CS_CODE1: assert property (!SPI_CS1_N |-> cs_sel == CS_SEL1 && SPI_CS0_N)
        else $error("select one low without code 01");
    AST_CS_RUN: assert property (byte_running |->
        (cs_sel == CS_SEL0) == !SPI_CS0_N && (cs_sel == CS_SEL1) == !SPI_CS1_N)
        else $error("chosen select not low during transaction");
    AST_CS_CLOSE: assert property (byte_closing |-> SPI_CS0_N && SPI_CS1_N)
        else $error("select not released after transaction");
    AST_IDLE_LEVEL: assert property (
        state_ff.phase == ST_IDLE && $past(state_ff.phase) == ST_IDLE |-> SPI_CLK == pol)
        else $error("clock not at polarity level while idle");
    AST_END_LEVEL: assert property (byte_running ##1 state_ff.phase == ST_DONE
        |-> SPI_CLK == pol)
        else $error("clock not back at rest after sixteen edges");
    AST_SAMPLE: assert property (state_ff.phase == ST_SHIFT && sample
        |=> state_ff.rx_sr == {$past(state_ff.rx_sr[6:0]), $past(state_ff.miso_sync)})
        else $error("receive bit not taken on chosen edge");
    AST_NO_SAMPLE: assert property (state_ff.phase == ST_SHIFT && !sample
        |=> $stable(state_ff.rx_sr))
        else $error("receive bit taken on wrong edge");
    AST_LAUNCH: assert property (state_ff.phase == ST_SHIFT && launch
        |=> SPI_MOSI == $past(state_ff.tx_sr[7]))
        else $error("transmit bit not launched on chosen edge");
    AST_HOLD: assert property (state_ff.phase == ST_SHIFT && !launch |=> $stable(SPI_MOSI))
        else $error("transmit data moved off its edge");
    AST_BUS_ANSWER: assert property (req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("bus access not answered in one wait cycle");
endmodule
`default_nettype wire

// *** sim/spi_slave_model.sv ***
`default_nettype none
module spi_slave_model
(
    input wire logic SCK,
    input wire logic CS_N,
    input wire logic MOSI,
    input wire logic SAMP_RISE,
    input wire logic LAUNCH_RISE,
    input wire logic [7:0] TX_BYTE,
    output logic MISO,
    output logic [7:0] RX_BYTE
);
    timeunit 1ns;
    timeprecision 1ns;
    int nsamp;
    initial
    begin
        MISO = 1'b0;
        RX_BYTE = 8'h00;
        nsamp = 0;
    end
    always @(negedge CS_N)
    begin
        nsamp = 0;
        MISO = TX_BYTE[7];
    end
    // Released line must not keep the last bit
    always @(posedge CS_N) MISO = ~MISO;
    // Capture opposite the master launch, shift opposite the master sample
    always @(SCK)
        if (CS_N === 1'b0)
        begin
            if (SCK != LAUNCH_RISE) RX_BYTE = {RX_BYTE[6:0], MOSI};
            if (SCK == SAMP_RISE) nsamp++;
            else if (nsamp < 8) MISO = TX_BYTE[7 - nsamp];
        end
endmodule
`default_nettype wire

// *** sim/tb_spi_clock_phase_cs_config.sv ***
`default_nettype none
module tb_spi_clock_phase_cs_config;
    timeunit 1ns;
    timeprecision 1ns;
    import spi_cfg_pkg::*;
    logic clk, rst_n, rd, wr, sck, cs0_n, cs1_n, mosi, miso, wait_rq, psck, lo0, lo1;
    logic samp_r, lnch_r, pol, rxp, txp;
    logic [1:0] cs;
    logic [3:0] addr, be;
    logic [7:0] s_tx, s_rx, b;
    logic [31:0] wdata, rdata, q, d;
    int err_count, n_checks, nedge, run, hmin, hmax, dv, h;
    int unsigned seed = 27;

    spi_clock_phase_cs_config i_spi_clock_phase_cs_config (.CLK(clk), .RESET_N(rst_n),
        .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
        .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_rq),
        .SPI_CLK(sck), .SPI_CS0_N(cs0_n), .SPI_CS1_N(cs1_n), .SPI_MOSI(mosi),
        .SPI_MISO(miso));
    spi_slave_model i_spi_slave_model (.SCK(sck), .CS_N(cs0_n & cs1_n), .MOSI(mosi),
        .SAMP_RISE(samp_r), .LAUNCH_RISE(lnch_r), .TX_BYTE(s_tx), .MISO(miso),
        .RX_BYTE(s_rx));

    function automatic int unsigned xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // One edge first so a new request never lands in the release step
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] dt,
                       output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk);
        addr <= a;
        wdata <= dt;
        wr <= w;
        rd <= !w;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wait_rq !== 1'b0);
        r = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        chk("bus wait", 2, n);
    endtask

    task automatic xfer(input logic [7:0] bt, output logic [31:0] st);
        nedge = 0;
        hmin = 9999;
        hmax = 0;
        lo0 = 0;
        lo1 = 0;
        bus(1'b1, XFER_OFS, {24'h0, bt}, st);
        do
        begin
            bus(1'b0, XFER_OFS, 32'h0, st);
        end
        while (st[BUSY_BIT] !== 1'b0);
    endtask

    // Half-period lengths and select activity seen at the pins
    always @(posedge clk)
    begin
        if (sck !== psck)
        begin
            nedge++;
            if (nedge > 1 && run < hmin) hmin = run;
            if (nedge > 1 && run > hmax) hmax = run;
            run = 1;
        end
        else
            run++;
        psck = sck;
        if (cs0_n === 1'b0) lo0 = 1;
        if (cs1_n === 1'b0) lo1 = 1;
    end

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial
    begin
        repeat (60000) @(posedge clk);
        err_count++;
        final_report();
    end

    initial
    begin
        rst_n = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        addr = 4'h0;
        wdata = 32'h0;
        be = 4'hF;
        s_tx = 8'h00;
        samp_r = 1'b1;
        lnch_r = 1'b0;
        psck = 1'b0;
        run = 0;
        err_count = 0;
        n_checks = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        chk("reset pins", 3'b110, {cs1_n, cs0_n, sck});
        bus(1'b0, MODE_OFS, 32'h0, q);
        chk("mode reset", MODE_RST, q);
        bus(1'b0, 4'h8, 32'h0, q);
        chk("unmapped", 32'h0, q);
        d = xs() & 32'hFFFF_FFFD;
        bus(1'b1, MODE_OFS, d, q);
        bus(1'b0, MODE_OFS, 32'h0, q);
        chk("mode rw", d & MODE_WMASK, q);
        // Only lane 1 may land
        be <= 4'h2;
        bus(1'b1, MODE_OFS, 32'hFFFF_FFFF, q);
        be <= 4'hF;
        bus(1'b0, MODE_OFS, 32'h0, q);
        chk("lane write", (d | 32'h0000_FF00) & MODE_WMASK, q);
        bus(1'b1, MODE_OFS, 32'h0000_0002, q);
        bus(1'b0, MODE_OFS, 32'h0, q);
        chk("soft reset", 32'h0, q);
        xfer(8'hA5, q);
        chk("inactive cs", 2'b00, {lo1, lo0});
        // All polarity and phase pairs, standard and same-edge ones
        for (int i = 0; i < 8; i++)
        begin
            {pol, rxp, txp} = 3'(i);
            cs = 2'(i);
            dv = (i == 6) ? 0 : (i == 7) ? 6 : 8;
            h = (dv == 0) ? 128 : dv / 2;
            d = {8'h0, 8'(dv), 2'b0, cs, 1'b0, rxp, txp, pol, 7'h0, 1'b1};
            bus(1'b1, MODE_OFS, d, q);
            bus(1'b0, MODE_OFS, 32'h0, q);
            chk("mode cfg", d, q);
            lnch_r <= pol ^ txp;
            samp_r <= ~(pol ^ rxp);
            s_tx <= 8'(xs());
            b = 8'(xs());
            xfer(b, q);
            chk("clock edges", 16, nedge);
            chk("half max", h, hmax);
            chk("half min", h, hmin);
            chk("cs0 used", cs == 2'h0, lo0);
            chk("cs1 used", cs == 2'h1, lo1);
            chk("cs closed", 2'b11, {cs1_n, cs0_n});
            chk("clock idle", pol, sck);
            if (cs < 2'h2)
            begin
                chk("slave rx", b, s_rx);
                chk("master rx", s_tx, q[7:0]);
            end
        end
        // Clearing activate mid-byte must close the select and rest the clock
        bus(1'b1, MODE_OFS, 32'h0008_0001, q);
        lo0 = 0;
        bus(1'b1, XFER_OFS, 32'h0000_003C, q);
        bus(1'b1, MODE_OFS, 32'h0008_0000, q);
        bus(1'b0, XFER_OFS, 32'h0, q);
        chk("abort select used", 1, lo0);
        chk("abort busy", 0, q[BUSY_BIT]);
        chk("abort cs", 2'b11, {cs1_n, cs0_n});
        chk("abort clock", 0, sck);
        final_report();
    end
endmodule
`default_nettype wire
